// [rtl/luma_nr_consts.vh]
`ifndef LUMA_NR_CONSTS_VH
`define LUMA_NR_CONSTS_VH

// register offsets
`define NR_ADDR_GAINS 8'h63
`define NR_ADDR_THRESH 8'h64
`define NR_ADDR_FILT 8'h65
`define NR_ADDR_EDGE 8'h42
`define NR_REG_RESET 8'h00
`define NR_READ_NONE 8'h00

// noise_coring_gains fields
`define NR_BORDER_GAIN_LSB 0
`define NR_BORDER_GAIN_MSB 3
`define NR_DATA_GAIN_LSB 4
`define NR_DATA_GAIN_MSB 7

// noise_threshold_block_shape fields
`define NR_THRESH_LSB 0
`define NR_THRESH_MSB 5
`define NR_BORDER_WIDE_BIT 6
`define NR_BLOCK_LARGE_BIT 7

// noise_filter_mode_offset fields
`define NR_FSEL_LSB 0
`define NR_FSEL_MSB 2
`define NR_MODE_BIT 4
`define NR_OFFSET_LSB 4
`define NR_OFFSET_MSB 7

// edge softening enable
`define NR_EDGE_EN_BIT 7
`define NR_EDGE_MASK 8'h80

// block grid masks, position within block
`define NR_BLK_MASK_SMALL 4'h7
`define NR_BLK_MASK_LARGE 4'hf
`define NR_POS_ZERO 4'h0
`define NR_POS_ONE 4'h1
`define NR_POS_STEP 4'h1

// gain scaling
`define NR_GAIN_SAT 4'h8
`define NR_CORE_SHIFT 3
`define NR_BOOST_SHIFT 4

// leading sample counter
`define NR_LEAD_ZERO 2'h0
`define NR_LEAD_MAX 2'h3
`define NR_LEAD_ONE 2'h1
`define NR_LEAD_TWO 2'h2

// luma range and fifo shape
`define NR_LUMA_MAX 12'h0ff
`define NR_LUMA_W 8
`define NR_WIN_LEN 5
`define NR_FIFO_W 9
`define NR_FIFO_DEPTH 4
`define NR_FIFO_AW 2

`endif

// [rtl/sd_luma_noise_reduction.v]
`timescale 1ns/1ps
`default_nettype none
`include "luma_nr_consts.vh"

// small output buffer; its ready stalls the whole pixel window
module luma_fifo #(
  parameter WIDTH = `NR_FIFO_W,
  parameter DEPTH = `NR_FIFO_DEPTH,
  parameter AW = `NR_FIFO_AW
) (
  input wire clk_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  // fill level thresholds at counter width
  localparam [AW:0] FULL = DEPTH[AW:0];
  localparam [AW:0] EMPTY = {(AW+1){1'b0}};
  // one-step constants, so no increment pads a bit
  localparam [AW-1:0] PTR_STEP = {{(AW-1){1'b0}}, 1'b1};
  localparam [AW:0] CNT_STEP = {{AW{1'b0}}, 1'b1};
  // storage is plain flops; four words cost little
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;
  integer i;

  // depth is a power of two so pointers wrap on their own
  assign in_ready_o = (count_reg != FULL);
  assign out_valid_o = (count_reg != EMPTY);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_reg[rd_ptr_reg];

  // storage and pointers
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= EMPTY;
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_reg[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data_i;
        wr_ptr_reg <= wr_ptr_reg + PTR_STEP;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PTR_STEP;
      end
      if (push && !pop) begin
        count_reg <= count_reg + CNT_STEP;
      end else if (pop && !push) begin
        count_reg <= count_reg - CNT_STEP;
      end
    end
  end
endmodule

// How it works
// - luma only; filter magnitude compared with threshold
// - coring: below threshold, subtract gained filter output
// - boost: above threshold, add gained filter output
// - border areas use low nibble gain
// - block interior uses high nibble gain
// - coring gain is code times one eighth, at most one
// - boost gain is code times one sixteenth, at most one half
// - threshold is six-bit unsigned magnitude
// - border area two or four pixels wide
// - block grid eight or sixteen pixels
// - three bits pick the detail filter
// - mode bit picks coring or boost
// - four-bit offset shifts block grid per pixel
// - soften first/last three samples by scale steps
// - other active samples pass edge stage untouched
module sd_luma_noise_reduction (
  input wire clk_i,
  input wire rst_i,
  input wire reg_we_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire pix_valid_i,
  output wire pix_ready_o,
  input wire [7:0] luma_i,
  input wire active_i,
  output wire pix_valid_o,
  input wire pix_ready_i,
  output wire [7:0] luma_o,
  output wire active_o
);
  // control registers
  reg [7:0] gains_reg;
  reg [7:0] thresh_reg;
  reg [7:0] filt_reg;
  reg edge_en_reg;

  // five-sample window, index 0 newest; sample 3 is the one processed
  reg [7:0] win_reg [0:`NR_WIN_LEN-1];
  reg [4:0] act_reg;
  reg [3:0] hpos_reg;
  // saturates at three: only the first three positions matter
  reg [1:0] lead_reg;

  // stream handshake and loop index
  wire fifo_ready;
  wire adv;
  integer k;

  // one pixel per accepted strobe; a full buffer freezes the window
  assign adv = pix_valid_i & fifo_ready;
  assign pix_ready_o = fifo_ready;

  // register writes
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gains_reg <= `NR_REG_RESET;
      thresh_reg <= `NR_REG_RESET;
      filt_reg <= `NR_REG_RESET;
      edge_en_reg <= 1'b0;
    end else if (reg_we_i) begin
      case (reg_addr_i)
        `NR_ADDR_GAINS: gains_reg <= reg_wdata_i;
        `NR_ADDR_THRESH: thresh_reg <= reg_wdata_i;
        `NR_ADDR_FILT: filt_reg <= reg_wdata_i;
        `NR_ADDR_EDGE: edge_en_reg <= reg_wdata_i[`NR_EDGE_EN_BIT];
        default: ;
      endcase
    end
  end

  // registered readback, unmapped offsets read zero
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= `NR_READ_NONE;
    end else begin
      case (reg_addr_i)
        `NR_ADDR_GAINS: reg_rdata_o <= gains_reg;
        `NR_ADDR_THRESH: reg_rdata_o <= thresh_reg;
        `NR_ADDR_FILT: reg_rdata_o <= filt_reg;
        `NR_ADDR_EDGE: reg_rdata_o <= edge_en_reg ? `NR_EDGE_MASK : `NR_READ_NONE;
        default: reg_rdata_o <= `NR_READ_NONE;
      endcase
    end
  end

  // field decode
  wire [3:0] border_gain = gains_reg[`NR_BORDER_GAIN_MSB:`NR_BORDER_GAIN_LSB];
  wire [3:0] data_gain = gains_reg[`NR_DATA_GAIN_MSB:`NR_DATA_GAIN_LSB];
  // threshold and block shape
  wire [5:0] thresh = thresh_reg[`NR_THRESH_MSB:`NR_THRESH_LSB];
  wire border_wide = thresh_reg[`NR_BORDER_WIDE_BIT];
  wire block_large = thresh_reg[`NR_BLOCK_LARGE_BIT];
  // filter pick and mode
  wire [2:0] fsel = filt_reg[`NR_FSEL_MSB:`NR_FSEL_LSB];
  wire boost_mode = filt_reg[`NR_MODE_BIT];
  // offset shares bit 4 with the mode bit, so odd offsets force boost mode
  wire [3:0] blk_offset = filt_reg[`NR_OFFSET_MSB:`NR_OFFSET_LSB];

  // sample window shift; line position of the sample entering slot 3
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (k = 0; k < `NR_WIN_LEN; k = k + 1) begin
        win_reg[k] <= 8'h00;
      end
      act_reg <= 5'h00;
      hpos_reg <= `NR_POS_ZERO;
      lead_reg <= `NR_LEAD_ZERO;
    end else if (adv) begin
      win_reg[0] <= luma_i;
      for (k = 1; k < `NR_WIN_LEN; k = k + 1) begin
        win_reg[k] <= win_reg[k-1];
      end
      // active flags travel with their samples
      act_reg <= {act_reg[3:0], active_i};
      if (act_reg[2] && !act_reg[3]) begin
        hpos_reg <= `NR_POS_ZERO;
        lead_reg <= `NR_LEAD_ZERO;
      end else begin
        hpos_reg <= hpos_reg + `NR_POS_STEP;
        lead_reg <= (lead_reg == `NR_LEAD_MAX) ? `NR_LEAD_MAX : lead_reg + `NR_LEAD_ONE;
      end
    end
  end

  // detail filter on neighbours; older sample is left
  wire signed [10:0] c_s = {3'b000, win_reg[3]};
  wire signed [10:0] l_s = {3'b000, win_reg[4]};
  wire signed [10:0] r_s = {3'b000, win_reg[2]};
  wire signed [10:0] hp_sym = (c_s <<< 1) - l_s - r_s;
  wire signed [10:0] hp_edge = (c_s - l_s) <<< 1;
  // bit 2 picks symmetric or one-sided shape, low bits attenuate
  wire signed [10:0] hp_raw = fsel[2] ? hp_edge : hp_sym;
  wire signed [10:0] filt_out = hp_raw >>> fsel[1:0];
  wire [10:0] filt_mag = filt_out[10] ? (11'h000 - filt_out) : filt_out;
  // equal to the threshold is neither noise nor detail
  wire is_noise = (filt_mag < {5'b00000, thresh});
  wire is_detail = (filt_mag > {5'b00000, thresh});

  // block grid position with offset applied
  wire [3:0] blk_mask = block_large ? `NR_BLK_MASK_LARGE : `NR_BLK_MASK_SMALL;
  wire [3:0] blk_pos = (hpos_reg + blk_offset) & blk_mask;
  // narrow border: last and first pixel of a block
  wire edge_narrow = (blk_pos == blk_mask) || (blk_pos == `NR_POS_ZERO);
  wire edge_extra = (blk_pos == blk_mask - `NR_POS_ONE) || (blk_pos == `NR_POS_ONE);
  wire on_border = edge_narrow || (border_wide && edge_extra);

  // gain pick and saturation at one (coring) or one half (boost)
  wire [3:0] gain_code = on_border ? border_gain : data_gain;
  // codes above eight saturate
  wire [3:0] gain_sat = (gain_code > `NR_GAIN_SAT) ? `NR_GAIN_SAT : gain_code;
  // operands widened to product width before the multiply
  wire signed [15:0] filt_wide = {{5{filt_out[10]}}, filt_out};
  wire signed [15:0] gain_wide = {12'h000, gain_sat};
  wire signed [15:0] prod = filt_wide * gain_wide;
  // arithmetic shifts round toward minus infinity
  wire signed [15:0] core_amt = prod >>> `NR_CORE_SHIFT;
  wire signed [15:0] boost_amt = prod >>> `NR_BOOST_SHIFT;

  // apply correction; boost leaves noise untouched, coring leaves detail
  reg signed [11:0] nr_sum;
  reg [7:0] nr_luma;
  always @* begin
    nr_sum = {4'h0, win_reg[3]};
    if (!boost_mode && is_noise) begin
      nr_sum = {4'h0, win_reg[3]} - core_amt[11:0];
    end else if (boost_mode && is_detail) begin
      nr_sum = {4'h0, win_reg[3]} + boost_amt[11:0];
    end
    // clamp back into the eight-bit luma range
    if (nr_sum < 12'sh000) begin
      nr_luma = 8'h00;
    end else if (nr_sum > $signed(`NR_LUMA_MAX)) begin
      nr_luma = 8'hff;
    end else begin
      nr_luma = nr_sum[7:0];
    end
  end

  // edge position: leading from counter, trailing from lookahead
  wire lead_first = (lead_reg == `NR_LEAD_ZERO);
  wire lead_second = (lead_reg == `NR_LEAD_ONE);
  wire lead_third = (lead_reg == `NR_LEAD_TWO);
  wire trail_last = !act_reg[2];
  wire trail_second = !act_reg[1];
  wire trail_third = !act_reg[0];
  // scale steps; seven eighths reuses the one-eighth shift
  wire [7:0] scale_eighth = {3'b000, nr_luma[7:3]};
  wire [7:0] scale_half = {1'b0, nr_luma[7:1]};
  wire [7:0] scale_seven = nr_luma - {3'b000, nr_luma[7:3]};

  // softening; short lines favour the leading scale
  reg [7:0] out_luma;
  always @* begin
    out_luma = win_reg[3];
    if (act_reg[3]) begin
      out_luma = nr_luma;
      if (edge_en_reg) begin
        if (lead_first || (trail_last && !lead_second && !lead_third)) begin
          out_luma = scale_eighth;
        end else if (lead_second || (trail_second && !lead_third)) begin
          out_luma = scale_half;
        end else if (lead_third || trail_third) begin
          out_luma = scale_seven;
        end
      end
    end
  end

  // blanking samples travel too, so output timing follows input
  wire [`NR_FIFO_W-1:0] fifo_out;
  luma_fifo #(
    .WIDTH(`NR_FIFO_W),
    .DEPTH(`NR_FIFO_DEPTH),
    .AW(`NR_FIFO_AW)
  ) out_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(adv),
    .in_ready_o(fifo_ready),
    .in_data_i({act_reg[3], out_luma}),
    .out_valid_o(pix_valid_o),
    .out_ready_i(pix_ready_i),
    .out_data_o(fifo_out)
  );

  // buffer word splits back into sample and active flag
  assign luma_o = fifo_out[`NR_LUMA_W-1:0];
  assign active_o = fifo_out[`NR_LUMA_W];
endmodule

`default_nettype wire

// [testbench/luma_nr_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// watches the register port and the output buffer handshake
module luma_nr_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_we_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic pix_valid_i,
  input wire logic pix_ready_o,
  input wire logic pix_valid_o,
  input wire logic pix_ready_i,
  input wire logic [7:0] luma_o,
  input wire logic active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // edge register left out: it keeps only one bit
  wire full_reg = reg_addr_i == 8'h63 || reg_addr_i == 8'h64 || reg_addr_i == 8'h65;
  wire mapped = full_reg || reg_addr_i == 8'h42;
  // register port
  chk_unmapped_zero: assert property (!mapped |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_write_readback: assert property (
    reg_we_i && full_reg ##1 $stable(reg_addr_i) && !reg_we_i
    |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("readback differs from write");
  chk_edge_bit_only: assert property (reg_addr_i == 8'h42 |=> reg_rdata_o[6:0] == 7'h00)
    else $error("edge register shows low bits");
  chk_reset_state: assert property ($fell(rst_i) |->
    !pix_valid_o && pix_ready_o && reg_rdata_o == 8'h00) else $error("bad state after reset");
  // output buffer handshake
  chk_out_hold: assert property (pix_valid_o && !pix_ready_i |=>
    pix_valid_o && $stable(luma_o) && $stable(active_o)) else $error("output word not held");
  chk_empty_ready: assert property (!pix_valid_o |-> pix_ready_o)
    else $error("empty buffer refuses input");
  chk_full_stays: assert property (!pix_ready_o && !pix_ready_i |=> !pix_ready_o)
    else $error("full buffer freed without a read");
  chk_valid_cause: assert property ($rose(pix_valid_o) |-> $past(pix_valid_i && pix_ready_o))
    else $error("output appeared without input");
  cov_full: cover property (!pix_ready_o);
  cov_stall_out: cover property (pix_valid_o && !pix_ready_i);
  cov_write: cover property (reg_we_i && full_reg);
endmodule
bind sd_luma_noise_reduction luma_nr_checker i_chk (.clk_i, .rst_i, .reg_we_i, .reg_addr_i,
  .reg_wdata_i, .reg_rdata_o, .pix_valid_i, .pix_ready_o, .pix_valid_o, .pix_ready_i,
  .luma_o, .active_o);
`default_nettype wire

// [testbench/luma_source.sv]
`timescale 1ns/1ps
`default_nettype none
// upstream luma source, one sample per pixel
module luma_source (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [7:0] luma_o,
  output logic active_o
);
  initial begin
    valid_o = 1'b0;
    luma_o = 8'h00;
    active_o = 1'b0;
  end
  // ready comes from flops, so checking it at the falling edge is safe
  task send(input logic [7:0] y, input logic a);
    begin
      @(negedge clk_i);
      valid_o = 1'b1;
      luma_o = y;
      active_o = a;
      while (!ready_i) @(negedge clk_i);
      @(posedge clk_i);
    end
  endtask
  // released lines show the inverse, never a stale sample
  task idle;
    begin
      @(negedge clk_i);
      valid_o = 1'b0;
      luma_o = ~luma_o;
      active_o = ~active_o;
    end
  endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_we_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic pix_ready_i = 1'b1;
  wire logic [7:0] reg_rdata_o, luma_o, luma_i;
  wire logic pix_valid_i, pix_ready_o, active_i, pix_valid_o, active_o;
  int errors = 0;
  int num_checks = 0;
  int skip = 4;
  int cyc = 0;
  logic [8:0] outq[$];
  logic [8:0] exq[$];
  always #4 clk_i = ~clk_i;
  sd_luma_noise_reduction i_dut (.clk_i, .rst_i, .reg_we_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .pix_valid_i, .pix_ready_o, .luma_i, .active_i, .pix_valid_o,
    .pix_ready_i, .luma_o, .active_o);
  luma_source i_src (.clk_i(clk_i), .ready_i(pix_ready_o), .valid_o(pix_valid_i),
    .luma_o(luma_i), .active_o(active_i));
  // capture delivered words; four reset fillers come out first; hang guard
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
    if (!rst_i && pix_valid_o && pix_ready_i) begin
      if (skip > 0) skip--;
      else outq.push_back({active_o, luma_o});
    end
  end
  task test_done;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    begin
      num_checks++;
      if (got !== exp) begin
        errors++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_pix(input logic [8:0] got, input logic [8:0] exp);
    begin
      num_checks++;
      if (got !== exp) begin
        errors++;
        $display("[ERR] %0t pixel got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    begin
      @(negedge clk_i);
      reg_we_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(negedge clk_i);
      reg_we_i = 1'b0;
    end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    begin
      @(negedge clk_i);
      reg_addr_i = a;
      @(negedge clk_i);
      chk8(reg_rdata_o, e);
    end
  endtask
  task put(input logic [7:0] y, input logic a, input logic [7:0] e);
    begin
      i_src.send(y, a);
      exq.push_back({a, e});
    end
  endtask
  // last four samples stay in the window until more input arrives
  task drain;
    begin
      i_src.idle();
      repeat (6) @(negedge clk_i);
      while (outq.size() > 0) chk_pix(outq.pop_front(), exq.pop_front());
    end
  endtask
  task t_regs;
    logic [7:0] a [5];
    logic [7:0] d [5];
    logic [7:0] e [5];
    begin
      a = '{8'h63, 8'h64, 8'h65, 8'h42, 8'h10};
      d = '{8'h5a, 8'hc5, 8'h13, 8'hff, 8'h77};
      e = '{8'h5a, 8'hc5, 8'h13, 8'h80, 8'h00};
      for (int i = 0; i < 5; i++) rd(a[i], 8'h00);
      for (int i = 0; i < 5; i++) wr(a[i], d[i]);
      for (int i = 0; i < 5; i++) rd(a[i], e[i]);
      $display("regs done");
    end
  endtask
  task t_soften;
    logic [7:0] e [9];
    begin
      e = '{8'h19, 8'h64, 8'haf, 8'hc8, 8'hc8, 8'hc8, 8'haf, 8'h64, 8'h19};
      wr(8'h63, 8'h00);
      wr(8'h42, 8'h80);
      put(8'hc8, 1'b0, 8'hc8);
      for (int i = 0; i < 9; i++) put(8'hc8, 1'b1, e[i]);
      repeat (4) put(8'hc8, 1'b0, 8'hc8);
      drain();
      wr(8'h42, 8'h00);
      $display("soften done");
    end
  endtask
  // flat line with one spike at pixel three; four blanking samples flush it
  task t_nr(input logic [7:0] r63, input logic [7:0] r64, input logic [7:0] r65,
    input logic [7:0] el, input logic [7:0] es, input logic [7:0] er);
    begin
      wr(8'h63, r63);
      wr(8'h64, r64);
      wr(8'h65, r65);
      put(8'h64, 1'b0, 8'h64);
      repeat (2) put(8'h64, 1'b1, 8'h64);
      put(8'h64, 1'b1, el);
      put(8'h68, 1'b1, es);
      put(8'h64, 1'b1, er);
      repeat (2) put(8'h64, 1'b1, 8'h64);
      repeat (4) put(8'h64, 1'b0, 8'h64);
      drain();
      $display("nr %h %h %h done", r63, r64, r65);
    end
  endtask
  // downstream stalls for twenty cycles; by then the buffer must refuse input
  task t_stall;
    begin
      pix_ready_i = 1'b0;
      fork
        begin
          repeat (20) @(negedge clk_i);
          chk8({7'h00, pix_ready_o}, 8'h00);
          pix_ready_i = 1'b1;
        end
      join_none
      repeat (8) put(8'h32, 1'b0, 8'h32);
      drain();
      $display("stall done");
    end
  endtask
  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    t_regs();
    t_soften();
    t_nr(8'h80, 8'h7f, 8'h00, 8'h68, 8'h60, 8'h68);
    t_nr(8'h80, 8'h40, 8'h00, 8'h64, 8'h68, 8'h64);
    t_nr(8'h80, 8'h85, 8'h10, 8'h64, 8'h6c, 8'h64);
    t_nr(8'h08, 8'h3f, 8'h41, 8'h64, 8'h64, 8'h66);
    t_stall();
    test_done();
  end
endmodule
`default_nettype wire
